// >>> hw/pods_consts.vh
// pods_consts.vh: offsets, field positions, reset values and timing counts
// assumes: included by the design files of the pwm offset / driver status block
`ifndef PODS_CONSTS_VH
`define PODS_CONSTS_VH

`define PODS_ADDR_W          7
`define PODS_DRIVER_STATUS_WORD_ADDR 7'h6f
`define PODS_PWM_CONF_ADDR   7'h70

`define PODS_OFS_LSB         0
`define PODS_OFS_MSB         7
`define PODS_OFS_RESET       8'h1e
`define PODS_GRAD_LSB        8
`define PODS_GRAD_MSB        15
`define PODS_GRAD_RESET      8'h00
`define PODS_AUTOSCALE_BIT   18
`define PODS_AUTOGRAD_BIT    19
`define PODS_CONF_RESET      32'h000c001e

`define PODS_STST_BIT        31
`define PODS_OLB_BIT         30
`define PODS_OLA_BIT         29
`define PODS_GROUND_SHORT_FLAG_B_BIT        28
`define PODS_GROUND_SHORT_FLAG_A_BIT        27

`define PODS_STST_CLOCKS     1048576
`define PODS_CS_FULL         5'h1f
`define PODS_CS_DIV_SHIFT    5
`define PODS_GRAD_MUL_SHIFT  8

`endif

// >>> hw/pods_idle_timer.v
// pods_idle_timer.v: counts clocks since the last step pulse, flags standstill
// assumes: step_i is a one-cycle pulse synchronous to clock_i
`timescale 1ns/1ps
module pods_idle_timer #(
  parameter IDLE_CLOCKS = 1048576,
  parameter CNT_W       = 21
) (
  // clock and reset
  input  wire clock_i,
  input  wire nrst_i,
  // step event
  input  wire step_i,
  // result
  output wire standstill_o
);
  reg  [CNT_W-1:0] count_reg;
  wire [CNT_W-1:0] limit = IDLE_CLOCKS[CNT_W-1:0];

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_reg <= {CNT_W{1'b0}};
    end else if (step_i) begin
      count_reg <= {CNT_W{1'b0}};
    end else if (count_reg != limit) begin
      count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign standstill_o = (count_reg == limit);
endmodule

// >>> hw/pods_status_bank.v
// pods_status_bank.v: amplitude offset configuration and upper driver status word
// assumes: register access is a simple synchronous read/write port from the serial
// interface logic; fault detectors and step input are synchronous to clock_i
// limitation: the manual amplitude path is one clock of combinational depth, divider included
// limitation: status bits 26..0 read as zero; their sources live outside this block
`timescale 1ns/1ps
`include "pods_consts.vh"
module pods_status_bank #(
  parameter STST_CLOCKS = `PODS_STST_CLOCKS,
  parameter STEP_W      = 20
) (
  // clock and reset
  input  wire              clock_i,
  input  wire              nrst_i,
  // register port
  input  wire [6:0]        reg_addr_i,
  input  wire              reg_wr_i,
  input  wire [31:0]       reg_wdata_i,
  output reg  [31:0]       reg_rdata_o,
  // off-time setting and disable pin
  input  wire [3:0]        off_time_setting_i,
  input  wire              driver_disable_input_i,
  // motion and regulation state
  input  wire              step_i,
  input  wire [STEP_W-1:0] step_period_measure_i,
  input  wire [4:0]        current_scale_i,
  input  wire              tune_done_i,
  input  wire [7:0]        tuned_gradient_i,
  input  wire [7:0]        auto_amplitude_i,
  input  wire [7:0]        lower_reg_threshold_i,
  // fault detectors
  input  wire              open_load_a_i,
  input  wire              open_load_b_i,
  input  wire              short_gnd_a_i,
  input  wire              short_gnd_b_i,
  // bridge side
  output reg  [7:0]        pwm_amplitude_o,
  output wire              bridge_enable_o,
  output wire [7:0]        pwm_amplitude_offset_o,
  output wire              autoscale_o
);
  reg  [31:0] conf_reg;
  reg  [7:0]  tuned_gradient_value_reg;
  reg         ground_short_flag_a_reg;
  reg         ground_short_flag_b_reg;
  reg  [7:0]  amp_next;
  wire        standstill;
  wire [7:0]  ofs  = conf_reg[`PODS_OFS_MSB:`PODS_OFS_LSB];
  wire [7:0]  grad = conf_reg[`PODS_GRAD_MSB:`PODS_GRAD_LSB];
  wire        autoscale = conf_reg[`PODS_AUTOSCALE_BIT];
  wire        autograd  = conf_reg[`PODS_AUTOGRAD_BIT];
  // the flags clear while the bridge is off by software or by pin
  wire        short_clear = (off_time_setting_i == 4'h0) || driver_disable_input_i;
  // writes to the status address or any other address are dropped without notice
  wire        conf_wr = reg_wr_i && (reg_addr_i == `PODS_PWM_CONF_ADDR);
  wire        short_latched = ground_short_flag_a_reg || ground_short_flag_b_reg;

  // manual amplitude terms, kept wide so saturation sees the true sum
  wire [13:0]      ofs_term    = ofs * ({1'b0, current_scale_i} + 6'h01);
  wire [15:0]      grad_term   = {grad, 8'h00};
  wire [15:0]      div_divisor = step_period_measure_i[15:0];
  wire [15:0]      div_quot;
  // remainder chain of the divider: slot k holds the partial remainder before bit 15-k
  wire [16*17-1:0] div_rem;
  wire [15:0]      grad_div;
  wire [16:0]      amp_sum;
  wire [7:0]       manual_amp;
  wire             period_zero = (step_period_measure_i == {STEP_W{1'b0}});
  // periods of 2^16 clocks and more make the gradient term vanish
  wire             period_long = ((step_period_measure_i >> 16) != {STEP_W{1'b0}});
  // offset zero holds the regulator at its floor so a sagging supply cannot lose control
  wire             floor_hold  = (ofs == 8'h00) && (auto_amplitude_i < lower_reg_threshold_i);
  genvar           k;

  assign div_rem[15:0] = 16'h0000;

  // one compare-and-subtract stage per quotient bit; a restoring divider spelled out
  // keeps the depth visible instead of leaving the divide operator to the tools
  generate
    for (k = 0; k < 16; k = k + 1) begin : g_div
      wire [16:0] shifted = {div_rem[k*16 +: 16], grad_term[15-k]};
      wire        fits    = (shifted >= {1'b0, div_divisor});
      wire [16:0] reduced = shifted - {1'b0, div_divisor};
      assign div_quot[15-k]          = fits;
      assign div_rem[(k+1)*16 +: 16] = fits ? reduced[15:0] : shifted[15:0];
    end
  endgenerate

  // a zero period stands for an infinitely fast step rate, so the term saturates
  assign grad_div   = period_zero ? 16'hffff :
                      period_long ? 16'h0000 :
                      div_quot;
  assign amp_sum    = {8'h00, ofs_term[13:`PODS_CS_DIV_SHIFT]} + {1'b0, grad_div};
  // saturation keeps a fast step rate from wrapping the amplitude back to a small value
  assign manual_amp = (amp_sum > 17'h000ff) ? 8'hff : amp_sum[7:0];

  // the idle count keeps its full width even when a shorter standstill time is set
  pods_idle_timer #(
    .IDLE_CLOCKS (STST_CLOCKS),
    .CNT_W       (21)
  ) u_idle (
    .clock_i      (clock_i),
    .nrst_i       (nrst_i),
    .step_i       (step_i),
    .standstill_o (standstill)
  );

  // the full word is stored so fields handled elsewhere read back as written
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conf_reg <= `PODS_CONF_RESET;
    end else if (conf_wr) begin
      conf_reg <= reg_wdata_i;
    end
  end

  // with autograd off the tuned value follows the user gradient
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tuned_gradient_value_reg <= `PODS_GRAD_RESET;
    end else if (!autograd || !autoscale) begin
      tuned_gradient_value_reg <= grad;
    end else if (tune_done_i) begin
      tuned_gradient_value_reg <= tuned_gradient_i;
    end
  end

  // set wins over clear so a fault in the clearing cycle is kept
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ground_short_flag_a_reg <= 1'b0;
    end else if (short_gnd_a_i) begin
      ground_short_flag_a_reg <= 1'b1;
    end else if (short_clear) begin
      ground_short_flag_a_reg <= 1'b0;
    end
  end

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ground_short_flag_b_reg <= 1'b0;
    end else if (short_gnd_b_i) begin
      ground_short_flag_b_reg <= 1'b1;
    end else if (short_clear) begin
      ground_short_flag_b_reg <= 1'b0;
    end
  end

  // open-load inputs deliberately absent here: they never stop the bridge
  assign bridge_enable_o = !short_latched && !short_clear;

  always @* begin
    if (!autoscale) begin
      amp_next = manual_amp;
    end else if (floor_hold) begin
      amp_next = lower_reg_threshold_i;
    end else begin
      amp_next = auto_amplitude_i;
    end
  end

  // registered so the bridge sees one settled amplitude per clock
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwm_amplitude_o <= 8'h00;
    end else begin
      pwm_amplitude_o <= amp_next;
    end
  end

  // status word: live open-load levels above the sticky short flags
  wire [31:0] status_word = {standstill,
                             open_load_b_i,
                             open_load_a_i,
                             ground_short_flag_b_reg,
                             ground_short_flag_a_reg,
                             27'h0000000};
  // bits 15..8 read back the tuned gradient, which follows the value last written while autograd or autoscale is off
  wire [31:0] conf_word   = {conf_reg[31:16], tuned_gradient_value_reg, conf_reg[7:0]};
  reg  [31:0] rdata_next;

  always @* begin
    case (reg_addr_i)
      `PODS_DRIVER_STATUS_WORD_ADDR: begin
        rdata_next = status_word;
      end
      `PODS_PWM_CONF_ADDR: begin
        rdata_next = conf_word;
      end
      default: begin
        rdata_next = 32'h00000000;
      end
    endcase
  end

  // read data are registered, so an address change shows one clock later
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 32'h00000000;
    end else begin
      reg_rdata_o <= rdata_next;
    end
  end

  assign pwm_amplitude_offset_o = ofs;
  assign autoscale_o            = autoscale;
endmodule

// >>> testbench/pods_host.sv
// pods_host.sv: host model issuing register reads and writes
// assumes: one clock; drives after the falling edge
`timescale 1ns/1ps
module pods_host (
  input  wire        clock_i,
  input  wire [31:0] rdata_i,
  output reg  [6:0]  addr_o = 7'h00,
  output reg         wr_o = 1'b0,
  output reg  [31:0] wdata_o = 32'h0
);
  task wr(input [6:0] a, input [31:0] v);
    begin
      @(negedge clock_i);
      addr_o = a;
      wr_o = 1'b1;
      wdata_o = v;
      @(negedge clock_i);
      wr_o = 1'b0;
      // stale data would hide a late capture
      wdata_o = ~v;
    end
  endtask
  task rd(input [6:0] a, output [31:0] v);
    begin
      @(negedge clock_i);
      addr_o = a;
      @(negedge clock_i);
      v = rdata_i;
    end
  endtask
endmodule

// >>> testbench/pods_properties.sv
// pods_properties.sv: port assertions for the status bank
// assumes: bound to pods_status_bank, one clock
`timescale 1ns/1ps
module pods_properties #(parameter STST_CLOCKS = 1048576) (
  input wire        clock_i, nrst_i, step_i, reg_wr_i, autoscale_o, bridge_enable_o,
  input wire        driver_disable_input_i, open_load_a_i, open_load_b_i,
  input wire        short_gnd_a_i, short_gnd_b_i,
  input wire [3:0]  off_time_setting_i,
  input wire [6:0]  reg_addr_i,
  input wire [31:0] reg_wdata_i, reg_rdata_o,
  input wire [7:0]  lower_reg_threshold_i, auto_amplitude_i, pwm_amplitude_o,
  input wire [7:0]  pwm_amplitude_offset_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  reg [20:0] idle_reg;
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) idle_reg <= 21'h0;
    else if (step_i) idle_reg <= 21'h0;
    else if (idle_reg < STST_CLOCKS) idle_reg <= idle_reg + 21'h1;
  end
  sequence s_flags_off;
    driver_disable_input_i && !short_gnd_a_i && !short_gnd_b_i ##1
    reg_addr_i == 7'h6f && !short_gnd_a_i && !short_gnd_b_i;
  endsequence
  a_short_trip: assert property ((short_gnd_a_i || short_gnd_b_i) |=> !bridge_enable_o)
    else $error("bridge on after short");
  a_short_flag: assert property (short_gnd_a_i ##1 reg_addr_i == 7'h6f |=> reg_rdata_o[27])
    else $error("short flag missing");
  a_bridge_cause: assert property ($fell(bridge_enable_o) |-> $past(short_gnd_a_i) ||
    $past(short_gnd_b_i) || off_time_setting_i == 4'h0 || driver_disable_input_i)
    else $error("bridge off without cause");
  a_off_hold: assert property (off_time_setting_i == 4'h0 || driver_disable_input_i
    |-> !bridge_enable_o) else $error("bridge on while disabled");
  a_ofs_write: assert property (reg_wr_i && reg_addr_i == 7'h70 |=>
    {24'h0, pwm_amplitude_offset_o} == ($past(reg_wdata_i) & 32'hff)) else $error("offset lost");
  a_open_live: assert property ($past(reg_addr_i) == 7'h6f |->
    reg_rdata_o[30] == $past(open_load_b_i) && reg_rdata_o[29] == $past(open_load_a_i))
    else $error("open load bits wrong");
  a_stst_time: assert property ($past(reg_addr_i) == 7'h6f |->
    reg_rdata_o[31] == ($past(idle_reg) >= STST_CLOCKS)) else $error("standstill timing");
  a_zero_floor: assert property ($past(nrst_i) && $past(autoscale_o) &&
    $past(pwm_amplitude_offset_o) == 8'h00 |-> pwm_amplitude_o >= $past(lower_reg_threshold_i))
    else $error("amplitude under floor");
  a_auto_pass: assert property ($past(nrst_i) && $past(autoscale_o) &&
    $past(pwm_amplitude_offset_o) != 8'h00 |-> pwm_amplitude_o == $past(auto_amplitude_i))
    else $error("amplitude clamped");
  a_flags_clear: assert property (s_flags_off |=> reg_rdata_o[28:27] == 2'b00)
    else $error("short flags stuck");
  sequence s_trip_in_clear;
    (short_gnd_a_i || short_gnd_b_i) && (off_time_setting_i == 4'h0 || driver_disable_input_i)
    ##1 !short_gnd_a_i && !short_gnd_b_i && off_time_setting_i != 4'h0 && !driver_disable_input_i;
  endsequence
  a_set_wins: assert property (s_trip_in_clear |-> !bridge_enable_o)
    else $error("short lost in clearing cycle");
endmodule
bind pods_status_bank pods_properties #(.STST_CLOCKS(STST_CLOCKS)) u_props (
  .clock_i(clock_i), .nrst_i(nrst_i), .step_i(step_i), .reg_wr_i(reg_wr_i),
  .autoscale_o(autoscale_o), .bridge_enable_o(bridge_enable_o),
  .driver_disable_input_i(driver_disable_input_i), .open_load_a_i(open_load_a_i),
  .open_load_b_i(open_load_b_i), .short_gnd_a_i(short_gnd_a_i), .short_gnd_b_i(short_gnd_b_i),
  .off_time_setting_i(off_time_setting_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .lower_reg_threshold_i(lower_reg_threshold_i),
  .auto_amplitude_i(auto_amplitude_i), .pwm_amplitude_o(pwm_amplitude_o),
  .pwm_amplitude_offset_o(pwm_amplitude_offset_o));

// >>> testbench/testbench.sv
// testbench.sv: register tests of the status bank via the host model
// assumes: 10 MHz clock, inputs changed on the falling edge
`timescale 1ns/1ps
module testbench;
  reg         clock_i = 1'b0, nrst_i = 1'b0, step = 1'b0, tdone = 1'b0, dis = 1'b0;
  reg  [1:0]  ol = 2'b00, sg = 2'b00;
  reg  [3:0]  off_time_setting = 4'h3;
  reg  [4:0]  cs = 5'h1f;
  reg  [7:0]  aamp = 8'h10;
  reg  [31:0] d;
  wire [31:0] wdata, rdata;
  wire [7:0]  amp, ofs;
  wire [6:0]  addr;
  wire        wr, ben, asc;
  integer     fail_count = 0, checks = 0, cyc = 0, i;
  pods_host h (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .wdata_o(wdata));
  pods_status_bank #(.STST_CLOCKS(64)) DUT (.clock_i(clock_i), .nrst_i(nrst_i),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .off_time_setting_i(off_time_setting), .driver_disable_input_i(dis), .step_i(step),
    .step_period_measure_i(20'h00100), .current_scale_i(cs), .tune_done_i(tdone),
    .tuned_gradient_i(8'h5a), .auto_amplitude_i(aamp), .lower_reg_threshold_i(8'h20),
    .open_load_a_i(ol[0]), .open_load_b_i(ol[1]), .short_gnd_a_i(sg[0]),
    .short_gnd_b_i(sg[1]), .pwm_amplitude_o(amp), .bridge_enable_o(ben),
    .pwm_amplitude_offset_o(ofs), .autoscale_o(asc));
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask
  initial begin
    forever #50 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      fail_count = fail_count + 1;
      complete_run;
    end
  end
  initial begin
    repeat (20) @(negedge clock_i);
    nrst_i = 1'b1;
    h.rd(7'h70, d);
    chk("conf", d, 32'h000c001e);
    chk("offset", {24'h0, ofs}, 32'h1e);
    chk("autoscale", {31'h0, asc}, 32'h1);
    h.wr(7'h70, 32'h00001040);
    h.rd(7'h70, d);
    chk("conf", d, 32'h00001040);
    chk("amp", {24'h0, amp}, 32'h50);
    chk("autoscale", {31'h0, asc}, 32'h0);
    cs = 5'h0f;
    @(negedge clock_i);
    chk("amp", {24'h0, amp}, 32'h30);
    h.wr(7'h70, 32'h0000ffff);
    h.rd(7'h10, d);
    chk("unmapped", d, 32'h0);
    chk("amp", {24'h0, amp}, 32'hff);
    $display("manual amplitude test done");
    repeat (60) @(negedge clock_i);
    h.rd(7'h6f, d);
    chk("status", d, 32'h80000000);
    step = 1'b1;
    ol = 2'b11;
    @(negedge clock_i);
    step = 1'b0;
    h.rd(7'h6f, d);
    chk("status", d, 32'h60000000);
    chk("bridge", {31'h0, ben}, 32'h1);
    repeat (60) @(negedge clock_i);
    h.rd(7'h6f, d);
    chk("status", d, 32'h60000000);
    h.rd(7'h6f, d);
    chk("status", d, 32'he0000000);
    for (i = 0; i < 2; i = i + 1) begin
      sg[i] = 1'b1;
      @(negedge clock_i);
      sg[i] = 1'b0;
      h.wr(7'h6f, 32'h0);
      h.rd(7'h6f, d);
      chk("status", d, 32'he0000000 | (32'h08000000 << i));
      chk("bridge", {31'h0, ben}, 32'h0);
      off_time_setting = (i == 0) ? 4'h0 : 4'h3;
      dis = (i == 1);
      @(negedge clock_i);
      off_time_setting = 4'h3;
      dis = 1'b0;
      h.rd(7'h6f, d);
      chk("status", d, 32'he0000000);
      chk("bridge", {31'h0, ben}, 32'h1);
    end
    sg = 2'b01;
    dis = 1'b1;
    @(negedge clock_i);
    sg = 2'b00;
    dis = 1'b0;
    h.rd(7'h6f, d);
    chk("status", d, 32'he8000000);
    off_time_setting = 4'h0;
    @(negedge clock_i);
    off_time_setting = 4'h3;
    h.rd(7'h6f, d);
    chk("status", d, 32'he0000000);
    $display("status test done");
    h.wr(7'h70, 32'h000c0000);
    tdone = 1'b1;
    @(negedge clock_i);
    tdone = 1'b0;
    h.rd(7'h70, d);
    chk("conf", d, 32'h000c5a00);
    chk("amp", {24'h0, amp}, 32'h20);
    aamp = 8'h30;
    @(negedge clock_i);
    chk("amp", {24'h0, amp}, 32'h30);
    aamp = 8'h10;
    h.wr(7'h70, 32'h000c0001);
    h.rd(7'h70, d);
    chk("amp", {24'h0, amp}, 32'h10);
    h.wr(7'h70, 32'h00041200);
    tdone = 1'b1;
    @(negedge clock_i);
    tdone = 1'b0;
    h.rd(7'h70, d);
    chk("conf", d, 32'h00041200);
    chk("offset", {24'h0, ofs}, 32'h0);
    chk("autoscale", {31'h0, asc}, 32'h1);
    $display("auto amplitude test done");
    complete_run;
  end
endmodule
